// >>> dcs_device.sv
// device end: cke state tracking, command legality and write mask
`timescale 1ns/10ps
`default_nettype none
module dcs_device (
  input wire logic clock_i,
  input wire logic nrst_i,
  dcs_link_if.dev link,
  input wire logic odt_enable_i,
  output logic [3:0] state_o,
  output logic active_pd_o,
  output logic illegal_o,
  output logic odt_on_o,
  output logic wr_beat_o,
  output logic [15:0] wr_data_o,
  output logic [7:0] op_o
);
  typedef struct packed {
    logic odt_s;
    logic cke_prev;
    dcs_pkg::dcs_state_t st;
    logic pd_active;
    logic [dcs_pkg::CNT_W-1:0] burst_cnt;
    logic [dcs_pkg::CNT_W-1:0] exit_cnt;
    logic [dcs_pkg::CNT_W-1:0] cke_hold;
    logic illegal;
    logic wr_beat;
    logic [15:0] wr_data;
    logic [7:0] op;
  } dcs_dev_t;

  dcs_dev_t s_q;
  dcs_dev_t s_d;
  logic [3:0] code;
  logic cke_n;
  logic idle_c;

  always_comb begin
    s_d = s_q;
    // pins come from logic on this clock: decoded as sampled, no synchroniser
    s_d.odt_s = link.odt;
    code = dcs_pkg::cmd_code(link.cs_n, link.ras_n, link.cas_n, link.we_n);
    cke_n = link.cke;
    idle_c = dcs_pkg::is_idle_cmd(code);
    s_d.cke_prev = cke_n;
    s_d.illegal = 1'b0;
    s_d.op = dcs_pkg::OP_NOP;
    s_d.wr_beat = 1'b0;
    // timed progression of burst and exit intervals
    if (s_q.burst_cnt != dcs_pkg::CNT_ZERO) begin
      s_d.burst_cnt = s_q.burst_cnt - dcs_pkg::CNT_ONE;
    end
    if (s_q.exit_cnt != dcs_pkg::CNT_ZERO) begin
      s_d.exit_cnt = s_q.exit_cnt - dcs_pkg::CNT_ONE;
    end
    if (cke_n != s_q.cke_prev) begin
      s_d.cke_hold = dcs_pkg::CNT_W'(dcs_pkg::MIN_CKE_PULSE - 1);
    end else if (s_q.cke_hold != dcs_pkg::CNT_ZERO) begin
      s_d.cke_hold = s_q.cke_hold - dcs_pkg::CNT_ONE;
    end
    // cke changed before it was held three edges
    if ((cke_n != s_q.cke_prev) && (s_q.cke_hold != dcs_pkg::CNT_ZERO)) begin
      s_d.illegal = 1'b1;
    end
    // write data mask: sampled with each beat while writing
    if (s_q.st == dcs_pkg::ST_WRITE && cke_n) begin
      if (!link.dm) begin
        s_d.wr_beat = 1'b1;
        s_d.wr_data = link.dq;
      end
    end
    unique case (s_q.st)
      dcs_pkg::ST_PDOWN, dcs_pkg::ST_SREF: begin
        // only a rising cke leaves; other inputs are don't care meanwhile
        if (!s_q.cke_prev && cke_n) begin
          if (!idle_c) begin
            s_d.illegal = 1'b1;
          end
          if (s_q.st == dcs_pkg::ST_SREF) begin
            s_d.st = dcs_pkg::ST_IDLE;
            // one counter covers the non-read and the read exit intervals
            s_d.exit_cnt = dcs_pkg::CNT_W'(dcs_pkg::XSRD_CLKS);
          end else begin
            s_d.st = s_q.pd_active ? dcs_pkg::ST_ACTIVE : dcs_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        if (s_q.cke_prev && !cke_n) begin
          if (idle_c && (s_q.st == dcs_pkg::ST_IDLE || s_q.st == dcs_pkg::ST_ACTIVE)) begin
            s_d.pd_active = (s_q.st == dcs_pkg::ST_ACTIVE);
            s_d.st = dcs_pkg::ST_PDOWN;
          end else if (code == dcs_pkg::CMD_REF && s_q.st == dcs_pkg::ST_IDLE) begin
            s_d.st = dcs_pkg::ST_SREF;
            s_d.op = dcs_pkg::OP_SREF_ENTER;
          end else begin
            s_d.illegal = 1'b1;
          end
        end else if (!s_q.cke_prev) begin
          // cke low on the previous edge outside power down (low to low or rising) is unlisted
          s_d.illegal = 1'b1;
        end else if (!idle_c && s_q.exit_cnt > dcs_pkg::CNT_W'(dcs_pkg::XSRD_CLKS
                     - dcs_pkg::XSNR_CLKS)) begin
          s_d.illegal = 1'b1;
        end else if (!idle_c) begin
          // cke high on both edges: command table applies
          unique case (s_q.st)
            dcs_pkg::ST_IDLE: begin
              if (code == dcs_pkg::CMD_ACT) begin
                s_d.st = dcs_pkg::ST_ACTIVE;
                s_d.op = dcs_pkg::OP_ACT;
              end else if (code == dcs_pkg::CMD_PRE) begin
                s_d.op = dcs_pkg::OP_PRE;
              end else if (code == dcs_pkg::CMD_REF) begin
                s_d.op = dcs_pkg::OP_REF;
              end else if (code == dcs_pkg::CMD_MRS) begin
                s_d.op = dcs_pkg::OP_MRS;
              end else begin
                s_d.illegal = 1'b1;
              end
            end
            dcs_pkg::ST_ACTIVE: begin
              if (code == dcs_pkg::CMD_RD && s_q.exit_cnt == dcs_pkg::CNT_ZERO) begin
                s_d.st = dcs_pkg::ST_READ;
                s_d.op = dcs_pkg::OP_RD;
                s_d.burst_cnt = dcs_pkg::CNT_W'(dcs_pkg::BURST_CYC);
              end else if (code == dcs_pkg::CMD_WR) begin
                s_d.st = dcs_pkg::ST_WRITE;
                s_d.op = dcs_pkg::OP_WR;
                s_d.burst_cnt = dcs_pkg::CNT_W'(dcs_pkg::BURST_CYC);
              end else if (code == dcs_pkg::CMD_PRE) begin
                s_d.st = dcs_pkg::ST_IDLE;
                s_d.op = dcs_pkg::OP_PRE;
              end else begin
                s_d.illegal = 1'b1;
              end
            end
            default: begin
              // bursts: same direction restarts, all else refused
              if ((s_q.st == dcs_pkg::ST_READ && code == dcs_pkg::CMD_RD) ||
                  (s_q.st == dcs_pkg::ST_WRITE && code == dcs_pkg::CMD_WR)) begin
                s_d.burst_cnt = dcs_pkg::CNT_W'(dcs_pkg::BURST_CYC);
                s_d.op = (code == dcs_pkg::CMD_RD) ? dcs_pkg::OP_RD : dcs_pkg::OP_WR;
                if (s_q.burst_cnt > dcs_pkg::CNT_ONE) begin
                  s_d.illegal = 1'b1;
                end
              end else begin
                s_d.illegal = 1'b1;
              end
            end
          endcase
        end else if ((s_q.st == dcs_pkg::ST_READ || s_q.st == dcs_pkg::ST_WRITE) &&
                     s_q.burst_cnt <= dcs_pkg::CNT_ONE) begin
          s_d.st = dcs_pkg::ST_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // cke idle level is high, so no false edge after reset
      s_q <= '{cke_prev: 1'b1,
               st: dcs_pkg::ST_IDLE,
               op: dcs_pkg::OP_NOP,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign state_o = {s_q.st == dcs_pkg::ST_SREF, s_q.st == dcs_pkg::ST_PDOWN,
                    s_q.st == dcs_pkg::ST_READ || s_q.st == dcs_pkg::ST_WRITE,
                    s_q.st != dcs_pkg::ST_IDLE};
  assign active_pd_o = s_q.pd_active && (s_q.st == dcs_pkg::ST_PDOWN);
  assign illegal_o = s_q.illegal;
  assign odt_on_o = odt_enable_i && s_q.odt_s && (s_q.st != dcs_pkg::ST_SREF);
  assign wr_beat_o = s_q.wr_beat;
  assign wr_data_o = s_q.wr_data;
  assign op_o = s_q.op;
endmodule : dcs_device
`default_nettype wire

// >>> dcs_pkg.sv
// shared constants and types for the ddr2 cke state and command legality ends
package dcs_pkg;
  // command codes: {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_DESEL = 4'h8;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned BURST_LEN = 4;
  localparam int unsigned BURST_CYC = BURST_LEN / 2;
  localparam int unsigned MIN_CKE_PULSE = 3;
  localparam int unsigned XSRD_CLKS = 200;
  localparam int unsigned XSNR_NS = 200;
  localparam int unsigned XSNR_CLKS = (XSNR_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ACTIVE = 6'h02,
    ST_READ = 6'h04,
    ST_WRITE = 6'h08,
    ST_PDOWN = 6'h10,
    ST_SREF = 6'h20
  } dcs_state_t;

  typedef enum logic [7:0] {
    OP_NOP = 8'h01,
    OP_ACT = 8'h02,
    OP_PRE = 8'h04,
    OP_RD = 8'h08,
    OP_WR = 8'h10,
    OP_REF = 8'h20,
    OP_MRS = 8'h40,
    OP_SREF_ENTER = 8'h80
  } dcs_op_t;

  // maps the four command pins to a command code
  function automatic logic [3:0] cmd_code(input logic cs_n, input logic ras_n,
                                          input logic cas_n, input logic we_n);
    cmd_code = cs_n ? CMD_DESEL : {1'b0, ras_n, cas_n, we_n};
  endfunction : cmd_code

  function automatic logic is_idle_cmd(input logic [3:0] code);
    is_idle_cmd = (code == CMD_NOP) || (code == CMD_DESEL);
  endfunction : is_idle_cmd
endpackage : dcs_pkg

// >>> dcs_link_if.sv
// command pins between the ddr2 controller end and the device end
`timescale 1ns/10ps
`default_nettype none
interface dcs_link_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic dm;
  logic [15:0] dq;
  modport ctrl (output cke, output cs_n, output ras_n, output cas_n, output we_n,
                output odt, output dm, output dq);
  modport dev (input cke, input cs_n, input ras_n, input cas_n, input we_n,
               input odt, input dm, input dq);
endinterface : dcs_link_if
`default_nettype wire

// >>> dcs_ctrl.sv
// controller end: drives requested commands and cke, spaced by its hold, burst and self refresh exit counters
`timescale 1ns/10ps
`default_nettype none
module dcs_ctrl (
  input wire logic clock_i,
  input wire logic nrst_i,
  dcs_link_if.ctrl link,
  input wire logic req_valid_i,
  input wire logic [3:0] req_cmd_i,
  input wire logic req_cke_i,
  input wire logic req_dm_i,
  input wire logic [15:0] req_data_i,
  input wire logic odt_i,
  input wire logic calib_i,
  output logic req_ready_o
);
  typedef struct packed {
    logic cke;
    logic [3:0] cmd;
    logic odt;
    logic dm;
    logic [15:0] dq;
    logic [dcs_pkg::CNT_W-1:0] hold;
    logic [dcs_pkg::CNT_W-1:0] xs_cnt;
    logic [dcs_pkg::CNT_W-1:0] burst;
    logic sref;
  } dcs_ctl_t;

  dcs_ctl_t s_q;
  dcs_ctl_t s_d;
  logic change;
  logic ok;

  always_comb begin
    s_d = s_q;
    s_d.cmd = dcs_pkg::CMD_NOP;
    s_d.odt = odt_i;
    if (s_q.hold != dcs_pkg::CNT_ZERO) begin
      s_d.hold = s_q.hold - dcs_pkg::CNT_ONE;
    end
    if (s_q.xs_cnt != dcs_pkg::CNT_ZERO) begin
      s_d.xs_cnt = s_q.xs_cnt - dcs_pkg::CNT_ONE;
    end
    if (s_q.burst != dcs_pkg::CNT_ZERO) begin
      s_d.burst = s_q.burst - dcs_pkg::CNT_ONE;
    end
    change = (req_cke_i != s_q.cke);
    ok = 1'b1;
    if (change && (s_q.hold != dcs_pkg::CNT_ZERO || calib_i)) begin
      ok = 1'b0;
    end
    if (change && !dcs_pkg::is_idle_cmd(req_cmd_i) &&
        !(req_cmd_i == dcs_pkg::CMD_REF && !req_cke_i)) begin
      ok = 1'b0;
    end
    if (change && !req_cke_i && s_q.burst != dcs_pkg::CNT_ZERO) begin
      ok = 1'b0;
    end
    if (!dcs_pkg::is_idle_cmd(req_cmd_i) && s_q.burst > dcs_pkg::CNT_ONE) begin
      ok = 1'b0;
    end
    if (!dcs_pkg::is_idle_cmd(req_cmd_i) && s_q.xs_cnt > dcs_pkg::CNT_W'(
        dcs_pkg::XSRD_CLKS - dcs_pkg::XSNR_CLKS)) begin
      ok = 1'b0;
    end
    if (req_cmd_i == dcs_pkg::CMD_RD && s_q.xs_cnt != dcs_pkg::CNT_ZERO) begin
      ok = 1'b0;
    end
    req_ready_o = ok;
    if (req_valid_i && ok) begin
      s_d.cmd = req_cmd_i;
      s_d.cke = req_cke_i;
      s_d.dm = req_dm_i;
      s_d.dq = req_data_i;
      if (change) begin
        s_d.hold = dcs_pkg::CNT_W'(dcs_pkg::MIN_CKE_PULSE - 1);
        s_d.sref = !req_cke_i && (req_cmd_i == dcs_pkg::CMD_REF);
        if (req_cke_i && s_q.sref) begin
          s_d.xs_cnt = dcs_pkg::CNT_W'(dcs_pkg::XSRD_CLKS);
        end
      end
      if (req_cmd_i == dcs_pkg::CMD_RD || req_cmd_i == dcs_pkg::CMD_WR) begin
        s_d.burst = dcs_pkg::CNT_W'(dcs_pkg::BURST_CYC);
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '{cke: 1'b1, cmd: dcs_pkg::CMD_NOP, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.cke = s_q.cke;
  assign link.cs_n = s_q.cmd[3];
  assign link.ras_n = s_q.cmd[2];
  assign link.cas_n = s_q.cmd[1];
  assign link.we_n = s_q.cmd[0];
  assign link.odt = s_q.odt;
  assign link.dm = s_q.dm;
  assign link.dq = s_q.dq;
endmodule : dcs_ctrl
`default_nettype wire

// >>> dcs_props.sv
// assertions on the link between the controller and device ends
`timescale 1ns/10ps
`default_nettype none
module dcs_props (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [3:0] state_o,
  input wire logic active_pd_o,
  input wire logic illegal_o,
  input wire logic odt_on_o,
  input wire logic [7:0] op_o
);
  logic [3:0] cmd;
  logic idle_c;
  logic cke_q;
  logic [7:0] gap_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  assign cmd = cs_n ? 4'h8 : {1'h0, ras_n, cas_n, we_n};
  assign idle_c = (cmd == 4'h7) || (cmd == 4'h8);
  // cycles since the last self refresh exit, saturating
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cke_q <= 1'h1;
      gap_q <= 8'hFF;
    end else begin
      cke_q <= cke;
      if (state_o[3] && cke && !cke_q) gap_q <= 8'h00;
      else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
    end
  end
  sequence s_sref_exit;
    state_o[3] && $rose(cke);
  endsequence
  sequence s_cke_fall;
    $past(cke) && !cke;
  endsequence
  AST_ACT_IDLE:
  assert property (state_o == 4'h0 && cmd == 4'h3 && cke && $past(cke) |-> ##[1:5] op_o == 8'h02)
    else $error("activate from idle not acted on");
  AST_SREF_IN:
  assert property (state_o == 4'h0 && cmd == 4'h1 ##0 s_cke_fall |-> ##[1:5] state_o[3])
    else $error("self refresh not entered");
  AST_PD_IN:
  assert property (state_o == 4'h1 && idle_c ##0 s_cke_fall |-> ##[1:5] active_pd_o)
    else $error("active power down not entered");
  AST_PD_OUT:
  assert property (state_o[2] && $rose(cke) |-> ##[1:5] !state_o[2])
    else $error("power down not left");
  AST_CKE_HOLD:
  assert property ($changed(cke) |=> $stable(cke)[*2])
    else $error("clock enable pulse too short");
  AST_CKE_NOP:
  assert property ($changed(cke) |-> idle_c || (cmd == 4'h1 && !cke))
    else $error("command with clock enable change");
  AST_SREF_QUIET:
  assert property (s_sref_exit |=> idle_c[*4])
    else $error("command too soon after self refresh exit");
  AST_RD_GAP:
  assert property (cmd == 4'h5 |-> gap_q >= 8'hC7)
    else $error("read too soon after self refresh exit");
  AST_BURST_ALONE:
  assert property (cmd == 4'h5 || cmd == 4'h4 |=> idle_c && cke)
    else $error("burst interrupted");
  AST_ODT_SREF:
  assert property (state_o[3] |-> !odt_on_o)
    else $error("termination on in self refresh");
  AST_NO_ILLEGAL:
  assert property (!illegal_o)
    else $error("legal stream flagged illegal");
endmodule : dcs_props
`default_nettype wire

// >>> ddr2_cke_state_command_legality_tb_top.sv
// self-checking bench joining the controller and device ends
`timescale 1ns/10ps
`default_nettype none
module ddr2_cke_state_command_legality_tb_top;
  logic clock_i;
  logic nrst_i;
  logic req_valid_i;
  logic [3:0] req_cmd_i;
  logic req_cke_i;
  logic req_dm_i;
  logic [15:0] req_data_i;
  logic odt_i;
  logic calib_i;
  logic odt_enable_i;
  logic req_ready_o;
  logic [3:0] state_o;
  logic active_pd_o;
  logic illegal_o;
  logic odt_on_o;
  logic wr_beat_o;
  logic [15:0] wr_data_o;
  logic [7:0] op_o;
  logic illegal_b;
  int n_errors;
  int n_compared;
  int beats;
  time t_take;
  time t_exit;
  dcs_link_if link();
  dcs_link_if link_b();
  dcs_ctrl dcs_ctrl_inst (.clock_i(clock_i), .nrst_i(nrst_i), .link(link),
    .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i), .req_cke_i(req_cke_i),
    .req_dm_i(req_dm_i), .req_data_i(req_data_i), .odt_i(odt_i), .calib_i(calib_i),
    .req_ready_o(req_ready_o));
  dcs_device dcs_device_inst (.clock_i(clock_i), .nrst_i(nrst_i), .link(link),
    .odt_enable_i(odt_enable_i), .state_o(state_o), .active_pd_o(active_pd_o),
    .illegal_o(illegal_o), .odt_on_o(odt_on_o), .wr_beat_o(wr_beat_o), .wr_data_o(wr_data_o),
    .op_o(op_o));
  // second device fed by a rule-breaking driver
  dcs_device dcs_device_inst_b (.clock_i(clock_i), .nrst_i(nrst_i), .link(link_b),
    .odt_enable_i(odt_enable_i), .state_o(), .active_pd_o(), .illegal_o(illegal_b),
    .odt_on_o(), .wr_beat_o(), .wr_data_o(), .op_o());
  dcs_props dcs_props_inst (.clock_i(clock_i), .nrst_i(nrst_i), .cke(link.cke),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .state_o(state_o), .active_pd_o(active_pd_o), .illegal_o(illegal_o),
    .odt_on_o(odt_on_o), .op_o(op_o));

  task automatic end_sim;
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request through the controller, then watch the device for the op
  task automatic run(input logic [3:0] c, input logic k, input logic m, input logic [7:0] op);
    int i;
    logic seen;
    @(posedge clock_i);
    req_valid_i <= 1'h1;
    req_cmd_i <= c;
    req_cke_i <= k;
    req_dm_i <= m;
    req_data_i <= 16'hA5C3;
    i = 0;
    do begin
      @(negedge clock_i);
      i++;
    end while (req_ready_o !== 1'h1 && i < 500);
    if (i >= 500) begin
      chk(16'h0001, 16'h0000);
      end_sim();
    end
    @(posedge clock_i);
    t_take = $time;
    req_valid_i <= 1'h0;
    req_cmd_i <= 4'h7;
    seen = 1'h0;
    repeat (8) begin
      @(negedge clock_i);
      seen = seen | (op_o === op);
      beats += int'(wr_beat_o === 1'h1);
    end
    chk(seen, 1'h1);
  endtask : run

  // drive the second link directly and count illegal flags
  task automatic drv_b(input logic [3:0] c, input logic k, input int gap, input int exp);
    int n;
    @(posedge clock_i);
    link_b.cke <= k;
    {link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} <= c;
    if (gap > 0) begin
      n = 0;
      @(posedge clock_i);
      {link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} <= 4'h7;
      repeat (gap) begin
        @(negedge clock_i);
        n += int'(illegal_b === 1'h1);
      end
      chk(16'(n), 16'(exp));
    end
  endtask : drv_b

  initial begin
    clock_i = 1'h0;
    forever #20 clock_i = ~clock_i;
  end

  initial begin
    nrst_i = 1'h0;
    req_valid_i = 1'h0;
    req_cmd_i = 4'h7;
    req_cke_i = 1'h1;
    req_dm_i = 1'h0;
    req_data_i = 16'h0000;
    odt_i = 1'h1;
    calib_i = 1'h0;
    odt_enable_i = 1'h1;
    link_b.cke = 1'h1;
    {link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = 4'h7;
    link_b.odt = 1'h0;
    link_b.dm = 1'h0;
    link_b.dq = 16'h0000;
    n_errors = 0;
    n_compared = 0;
    beats = 0;
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'h1;
    @(negedge clock_i);
    chk(state_o, 4'h0);
    run(4'h3, 1'h1, 1'h0, 8'h02);
    chk(state_o, 4'h1);
    chk(odt_on_o, 1'h1);
    @(posedge clock_i);
    calib_i <= 1'h1;
    req_valid_i <= 1'h1;
    req_cke_i <= 1'h0;
    repeat (4) @(negedge clock_i);
    chk(req_ready_o, 1'h0);
    @(posedge clock_i);
    calib_i <= 1'h0;
    req_valid_i <= 1'h0;
    run(4'h7, 1'h0, 1'h0, 8'h01);
    chk(active_pd_o, 1'h1);
    chk(state_o[2], 1'h1);
    run(4'h8, 1'h1, 1'h0, 8'h01);
    chk(state_o, 4'h1);
    beats = 0;
    run(4'h4, 1'h1, 1'h0, 8'h10);
    chk(beats != 0, 1'h1);
    chk(wr_data_o, 16'hA5C3);
    beats = 0;
    run(4'h4, 1'h1, 1'h1, 8'h10);
    chk(16'(beats), 16'h0000);
    run(4'h5, 1'h1, 1'h0, 8'h08);
    run(4'h2, 1'h1, 1'h0, 8'h04);
    chk(state_o, 4'h0);
    run(4'h7, 1'h0, 1'h0, 8'h01);
    chk({active_pd_o, state_o}, 5'h05);
    run(4'h7, 1'h1, 1'h0, 8'h01);
    chk(state_o, 4'h0);
    run(4'h1, 1'h1, 1'h0, 8'h20);
    run(4'h0, 1'h1, 1'h0, 8'h40);
    run(4'h1, 1'h0, 1'h0, 8'h80);
    chk(state_o[3], 1'h1);
    chk(odt_on_o, 1'h0);
    run(4'h7, 1'h1, 1'h0, 8'h01);
    t_exit = t_take;
    chk(state_o[3], 1'h0);
    run(4'h3, 1'h1, 1'h0, 8'h02);
    run(4'h5, 1'h1, 1'h0, 8'h08);
    chk(t_take - t_exit >= dcs_pkg::XSRD_CLKS * 40, 1'h1);
    drv_b(4'h5, 1'h1, 6, 1);
    drv_b(4'h3, 1'h1, 6, 0);
    drv_b(4'h3, 1'h1, 6, 1);
    drv_b(4'h1, 1'h1, 6, 1);
    drv_b(4'h0, 1'h1, 6, 1);
    drv_b(4'h4, 1'h1, 0, 0);
    drv_b(4'h5, 1'h1, 6, 1);
    drv_b(4'h3, 1'h0, 6, 6);
    end_sim();
  end
endmodule : ddr2_cke_state_command_legality_tb_top
`default_nettype wire
